// ### design/timer2_pkg.sv
package timer2_pkg;

    // ==========================================================
    // Register map (byte addresses on the plain register port)
    localparam logic [7:0] ADDR_CTRL = 8'hc8;
    localparam logic [7:0] ADDR_CNT_LO = 8'hca;
    localparam logic [7:0] ADDR_CNT_HI = 8'hcb;
    localparam logic [7:0] ADDR_RLD_LO = 8'hcc;
    localparam logic [7:0] ADDR_RLD_HI = 8'hcd;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] RLD_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Code address the interrupt controller jumps to for this timer
    localparam logic [7:0] IRQ_VECTOR = 8'h2b;

    // ==========================================================
    // Timing: the system clock is the oscillator
    localparam int OSC_PERIOD_NS = 25;
    localparam int OSC_PER_MC = 12;
    localparam int MIN_PIN_LEVEL_T = 12;
    localparam int MIN_PIN_LEVEL_CYC = (MIN_PIN_LEVEL_T * OSC_PERIOD_NS + OSC_PERIOD_NS - 1)
        / OSC_PERIOD_NS;
    localparam logic [3:0] PH_LAST = 4'(OSC_PER_MC - 1);
    localparam logic [3:0] PH_COUNT = 4'h2;
    localparam logic [3:0] PH_EXT = 4'h3;
    localparam logic [3:0] PH_ZERO = 4'h0;
    localparam logic [3:0] PH_STEP = 4'h1;

    // Serial port modes that take a variable bit clock
    localparam logic [1:0] SER_MODE1 = 2'h1;
    localparam logic [1:0] SER_MODE3 = 2'h3;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_RELOAD = 2'b00,
        MODE_CAPTURE = 2'b01,
        MODE_BAUD = 2'b10
    } mode_e;

    typedef struct packed {
        logic overflow_flag;
        logic external_flag;
        logic receive_clock_select;
        logic transmit_clock_select;
        logic external_edge_enable;
        logic run_bit;
        logic count_source_select;
        logic capture_reload_select;
    } ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    function automatic mode_e decode_mode(input ctrl_s c);
        mode_e m;
        m = MODE_RELOAD;
        if (c.receive_clock_select | c.transmit_clock_select) begin
            m = MODE_BAUD;
        end else if (c.capture_reload_select) begin
            m = MODE_CAPTURE;
        end
        return m;
    endfunction : decode_mode

endpackage : timer2_pkg

// ### design/timer2_reload_capture_baud.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module timer2_reload_capture_baud
    import timer2_pkg::*;
#(
    parameter int PHASES = OSC_PER_MC
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // Register port
    input timer2_pkg::reg_req_s reg_req_in,
    output logic [7:0] rd_data_out,
    // Pins
    input wire logic external_count_pin_in,
    input wire logic capture_reload_pin_in,
    // Power and serial port status
    input wire logic osc_stopped_in,
    input wire logic [1:0] serial_mode_in,
    // Requests and bit clocks
    output logic irq_out,
    output logic rx_baud_tick_out,
    output logic tx_baud_tick_out
);
    import timer2_pkg::*;

    if (PHASES != OSC_PER_MC) begin : g_bad_phases
        $error("PHASES must equal the machine cycle length");
    end

    // ==========================================================
    // State
    ctrl_s ctrl_r, ctrl_nxt;
    logic [15:0] count_r, count_nxt;
    logic [15:0] rld_r, rld_nxt;
    logic [3:0] ph_r, ph_nxt;
    logic half_r;
    logic cnt_s1_r, cnt_s2_r, cnt_s3_r;
    logic cap_s1_r, cap_s2_r, cap_s3_r;
    logic cnt_pend_r, cnt_pend_nxt;
    logic cap_pend_r, cap_pend_nxt;
    logic [7:0] rd_data_r;
    logic irq_r;
    logic rx_tick_r, tx_tick_r;

    // ==========================================================
    // Register decode
    wire sel_ctrl = reg_req_in.addr == ADDR_CTRL;
    wire sel_cnt_lo = reg_req_in.addr == ADDR_CNT_LO;
    wire sel_cnt_hi = reg_req_in.addr == ADDR_CNT_HI;
    wire sel_rld_lo = reg_req_in.addr == ADDR_RLD_LO;
    wire sel_rld_hi = reg_req_in.addr == ADDR_RLD_HI;
    wire wr_ctrl = reg_req_in.wr & sel_ctrl;
    wire wr_cnt_lo = reg_req_in.wr & sel_cnt_lo;
    wire wr_cnt_hi = reg_req_in.wr & sel_cnt_hi;
    wire wr_rld_lo = reg_req_in.wr & sel_rld_lo;
    wire wr_rld_hi = reg_req_in.wr & sel_rld_hi;
    wire cnt_wr = wr_cnt_lo | wr_cnt_hi;

    // Counter bytes read back raw; in baud mode they may be mid-update
    wire [7:0] rd_mux = sel_ctrl ? ctrl_r :
                        sel_cnt_lo ? count_r[7:0] :
                        sel_cnt_hi ? count_r[15:8] :
                        sel_rld_lo ? rld_r[7:0] :
                        sel_rld_hi ? rld_r[15:8] :
                        READ_IDLE;
    wire [7:0] rd_nxt = reg_req_in.rd ? rd_mux : READ_IDLE;

    // ==========================================================
    // Mode and timing
    wire mode_e mode = decode_mode(ctrl_r);
    wire is_baud = mode == MODE_BAUD;
    wire is_capture = mode == MODE_CAPTURE;
    wire is_reload = mode == MODE_RELOAD;

    // Phase counter freezes with the oscillator
    wire osc_run = ~osc_stopped_in;
    assign ph_nxt = !osc_run ? ph_r : (ph_r == PH_LAST) ? PH_ZERO : ph_r + PH_STEP;
    wire ph_count = osc_run & (ph_r == PH_COUNT);
    wire ph_ext = osc_run & (ph_r == PH_EXT);

    wire mc_tick = ph_count;
    wire half_tick = osc_run & half_r;
    wire int_tick = is_baud ? half_tick : mc_tick;

    // ==========================================================
    // Pin edge detectors
    wire cnt_fall = cnt_s3_r & ~cnt_s2_r;
    wire cap_fall = cap_s3_r & ~cap_s2_r & ctrl_r.external_edge_enable;
    // Pending edge survives power-down; consumed on next matching phase
    assign cnt_pend_nxt = cnt_fall | (cnt_pend_r & ~ph_count);
    assign cap_pend_nxt = cap_fall | (cap_pend_r & ~ph_ext);
    wire ext_tick = cnt_pend_r & ph_count;
    wire cap_evt = cap_pend_r & ph_ext;

    // ==========================================================
    // Counting
    wire run = ctrl_r.run_bit & osc_run;
    wire tick = run & (ctrl_r.count_source_select ? ext_tick : int_tick);
    wire carry = tick & (count_r == CNT_MAX);
    wire load_rld = run & ((carry & ~is_capture) | (cap_evt & is_reload));
    wire do_capture = run & cap_evt & is_capture;

    always_comb begin
        count_nxt = count_r;
        if (load_rld) begin
            count_nxt = rld_r;
        end else if (tick) begin
            count_nxt = count_r + CNT_ONE;
        end
        // Software byte writes win over the hardware step
        if (wr_cnt_lo) begin
            count_nxt[7:0] = reg_req_in.wdata;
        end
        if (wr_cnt_hi) begin
            count_nxt[15:8] = reg_req_in.wdata;
        end
    end

    always_comb begin
        rld_nxt = rld_r;
        if (wr_rld_lo) begin
            rld_nxt[7:0] = reg_req_in.wdata;
        end
        if (wr_rld_hi) begin
            rld_nxt[15:8] = reg_req_in.wdata;
        end
        // A capture on the same cycle beats a software write
        if (do_capture) begin
            rld_nxt = count_r;
        end
    end

    // ==========================================================
    // Control register and flags; a hardware set beats a clear
    wire ovf_set = carry & ~is_baud;
    always_comb begin
        ctrl_nxt = wr_ctrl ? ctrl_s'(reg_req_in.wdata) : ctrl_r;
        if (ovf_set) begin
            ctrl_nxt.overflow_flag = 1'b1;
        end
        if (cap_evt) begin
            ctrl_nxt.external_flag = 1'b1;
        end
    end

    // ==========================================================
    // Outputs to the interrupt controller and serial port
    wire irq_nxt = ctrl_r.overflow_flag | ctrl_r.external_flag;
    wire ser_var = (serial_mode_in == SER_MODE1) | (serial_mode_in == SER_MODE3);
    wire baud_carry = carry & is_baud & ser_var;
    wire rx_tick_nxt = baud_carry & ctrl_r.receive_clock_select;
    wire tx_tick_nxt = baud_carry & ctrl_r.transmit_clock_select;

    // ==========================================================
    // Flip-flops
    always_ff @(posedge sys_clk_in) begin
        cnt_s1_r <= external_count_pin_in;
        cnt_s2_r <= cnt_s1_r;
        cap_s1_r <= capture_reload_pin_in;
        cap_s2_r <= cap_s1_r;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            cnt_s3_r <= 1'b0;
            cap_s3_r <= 1'b0;
            cnt_pend_r <= 1'b0;
            cap_pend_r <= 1'b0;
            ph_r <= PH_ZERO;
            half_r <= 1'b0;
        end else begin
            cnt_s3_r <= cnt_s2_r;
            cap_s3_r <= cap_s2_r;
            cnt_pend_r <= cnt_pend_nxt;
            cap_pend_r <= cap_pend_nxt;
            ph_r <= ph_nxt;
            half_r <= half_r ^ osc_run;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            ctrl_r <= ctrl_s'(CTRL_RESET);
            count_r <= CNT_RESET;
            rld_r <= RLD_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
            count_r <= count_nxt;
            rld_r <= rld_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rd_data_r <= READ_IDLE;
            irq_r <= 1'b0;
            rx_tick_r <= 1'b0;
            tx_tick_r <= 1'b0;
        end else begin
            rd_data_r <= rd_nxt;
            irq_r <= irq_nxt;
            rx_tick_r <= rx_tick_nxt;
            tx_tick_r <= tx_tick_nxt;
        end
    end

    assign rd_data_out = rd_data_r;
    assign irq_out = irq_r;
    assign rx_baud_tick_out = rx_tick_r;
    assign tx_baud_tick_out = tx_tick_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_cap_fall;
        $fell(cap_s2_r) ##0 ctrl_r.external_edge_enable;
    endsequence

    sequence s_base_carry;
        carry ##0 !cnt_wr;
    endsequence

    a_run_freeze: assert property (
        (!ctrl_r.run_bit && !cnt_wr) |=> $stable(count_r))
        else $error("counter moved while run bit low");

    a_osc_freeze: assert property (
        (osc_stopped_in && !cnt_wr) |=> $stable(count_r))
        else $error("counter moved while oscillator stopped");

    a_carry_ovf: assert property (
        (carry && !is_baud) |=> ctrl_r.overflow_flag)
        else $error("carry did not set overflow flag");

    a_baud_no_ovf: assert property (
        (carry && is_baud && !ctrl_r.overflow_flag && !wr_ctrl) |=> !ctrl_r.overflow_flag)
        else $error("baud carry set overflow flag");

    a_carry_reload: assert property (
        (s_base_carry ##0 !is_capture) |=> (count_r == $past(rld_r)))
        else $error("carry did not reload counter");

    a_capture_copy: assert property (
        do_capture |=> (rld_r == $past(count_r)))
        else $error("capture did not copy counter");

    a_edge_flag: assert property (
        s_cap_fall |-> ##[1:13] ctrl_r.external_flag)
        else $error("pin fall did not set external flag");

    a_edge_gate: assert property (
        (!ctrl_r.external_edge_enable && !cap_pend_r) |=> !cap_pend_r)
        else $error("edge accepted while disabled");

    a_irq_flags: assert property (
        (ctrl_r.overflow_flag || ctrl_r.external_flag) |=> irq_out)
        else $error("flag set without interrupt request");

    a_tick_mode: assert property (
        rx_baud_tick_out |-> $past(ser_var) && $past(is_baud))
        else $error("receive tick outside variable serial mode");

    a_half_rate: assert property (
        (tick && is_baud && !ctrl_r.count_source_select) |=> !tick)
        else $error("baud internal tick faster than half rate");

    // ==========================================================
    // Sources, phases and register paths
    wire [7:0] rld_lo_byte = rld_r[7:0];
    wire [7:0] rld_hi_byte = rld_r[15:8];

    sequence s_int_step;
        tick ##0 !load_rld ##0 !cnt_wr;
    endsequence

    sequence s_rx_carry;
        carry ##0 is_baud ##0 ser_var ##0 ctrl_r.receive_clock_select;
    endsequence

    sequence s_tx_carry;
        carry ##0 is_baud ##0 ser_var ##0 ctrl_r.transmit_clock_select;
    endsequence

    a_count_step: assert property (
        s_int_step |=> (count_r == $past(count_r) + CNT_ONE))
        else $error("counter did not step by one");

    a_src_ext: assert property (
        (ctrl_r.count_source_select && !ext_tick) |-> !tick)
        else $error("external source counted without pin edge");

    a_halt_no_load: assert property (
        !ctrl_r.run_bit |-> (!load_rld && !do_capture))
        else $error("reload or capture while halted");

    a_phase_hold: assert property (
        osc_stopped_in |=> $stable(ph_r))
        else $error("phase moved while oscillator stopped");

    a_baud_decode: assert property (
        (ctrl_r.receive_clock_select || ctrl_r.transmit_clock_select) |-> is_baud)
        else $error("clock select did not force baud mode");

    a_edge_reload: assert property (
        (cap_evt && is_reload && ctrl_r.run_bit && !cnt_wr) |=> (count_r == $past(rld_r)))
        else $error("pin edge did not reload counter");

    a_gate_off: assert property (
        (!ctrl_r.external_edge_enable && !cap_pend_r && !ctrl_r.external_flag && !wr_ctrl)
        |=> !ctrl_r.external_flag)
        else $error("external flag set while edge disabled");

    a_flag_event: assert property (
        cap_evt |=> ctrl_r.external_flag)
        else $error("pin event did not set external flag");

    a_ovf_hold: assert property (
        (ctrl_r.overflow_flag && !wr_ctrl) |=> ctrl_r.overflow_flag)
        else $error("overflow flag cleared by hardware");

    a_irq_idle: assert property (
        (!ctrl_r.overflow_flag && !ctrl_r.external_flag) |=> !irq_out)
        else $error("interrupt request without flag");

    a_capture_hold: assert property (
        (do_capture && !tick && !cnt_wr) |=> $stable(count_r))
        else $error("capture disturbed the counter");

    a_rx_tick: assert property (
        s_rx_carry |=> rx_baud_tick_out)
        else $error("baud carry gave no receive tick");

    a_tx_tick: assert property (
        s_tx_carry |=> tx_baud_tick_out)
        else $error("baud carry gave no transmit tick");

    a_tx_mode: assert property (
        tx_baud_tick_out |-> $past(ser_var) && $past(is_baud))
        else $error("transmit tick outside variable serial mode");

    a_read_reload: assert property (
        (reg_req_in.rd && sel_rld_hi) |=> (rd_data_out == $past(rld_hi_byte)))
        else $error("reload high byte read back wrong");

    a_int_phase: assert property (
        (tick && !is_baud && !ctrl_r.count_source_select) |-> (ph_r == PH_COUNT))
        else $error("internal count off its machine phase");

    a_ext_phase: assert property (
        (tick && ctrl_r.count_source_select) |-> (ph_r == PH_COUNT && cnt_pend_r))
        else $error("pin count without pending edge");

    a_cap_phase: assert property (
        cap_evt |-> (ph_r == PH_EXT))
        else $error("capture pin acted off its phase");

    a_rld_write: assert property (
        (wr_rld_lo && !do_capture) |=> (rld_lo_byte == $past(reg_req_in.wdata)))
        else $error("reload low byte write lost");

endmodule : timer2_reload_capture_baud

// ### bench/timer2_far_side.sv
`timescale 1ns/1ps
// ==========================================================
// Far side: count pin and capture/reload pin drivers
module timer2_far_side (
    // Clock
    input wire logic sys_clk_in,
    // Pins, idle high like pulled-up port pins
    output logic external_count_pin_out,
    output logic capture_reload_pin_out
);
    initial begin
        external_count_pin_out = 1'b1;
        capture_reload_pin_out = 1'b1;
    end

    // One falling edge; 16 clocks per level keeps the 12 minimum
    task automatic pulse(input logic cap);
        @(posedge sys_clk_in);
        if (cap) begin
            capture_reload_pin_out <= 1'b0;
        end else begin
            external_count_pin_out <= 1'b0;
        end
        repeat (16) @(posedge sys_clk_in);
        external_count_pin_out <= 1'b1;
        capture_reload_pin_out <= 1'b1;
        repeat (16) @(posedge sys_clk_in);
    endtask : pulse
endmodule : timer2_far_side

// ### bench/timer2_reload_capture_baud_bench.sv
`timescale 1ns/1ps
module timer2_reload_capture_baud_bench;
    import timer2_pkg::*;
    logic sys_clk_in;
    logic rst_b_in;
    reg_req_s req;
    logic [7:0] rd_data_out;
    logic ext_pin;
    logic cap_pin;
    logic osc_stopped;
    logic [1:0] serial_mode;
    logic irq_out;
    logic rx_tick;
    logic tx_tick;
    int err_count = 0;
    int n_tests = 0;
    int rx_n = 0;
    int tx_n = 0;
    logic [7:0] row_a [6] = '{8'hcc, 8'hcd, 8'hca, 8'hcb, 8'hc8, 8'hc9};
    logic [7:0] row_d [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h03, 8'haa};
    logic [7:0] row_e [6] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h03, 8'h00};

    timer2_reload_capture_baud dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .reg_req_in(req), .rd_data_out(rd_data_out), .external_count_pin_in(ext_pin),
        .capture_reload_pin_in(cap_pin), .osc_stopped_in(osc_stopped),
        .serial_mode_in(serial_mode), .irq_out(irq_out), .rx_baud_tick_out(rx_tick),
        .tx_baud_tick_out(tx_tick));
    timer2_far_side far_u (.sys_clk_in(sys_clk_in), .external_count_pin_out(ext_pin),
        .capture_reload_pin_out(cap_pin));

    initial begin
        sys_clk_in = 1'b0;
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        if (rx_tick === 1'b1) rx_n++;
        if (tx_tick === 1'b1) tx_n++;
    end

    // ==========================================================
    // Report and bus tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
        // Data stand only in the cycle after the strobe
        @(negedge sys_clk_in);
        chk(rd_data_out, exp);
        @(posedge sys_clk_in);
    endtask : rchk
    task automatic wait_irq();
        int i;
        for (i = 0; i < 60 && irq_out !== 1'b1; i++) @(posedge sys_clk_in);
        chk({7'h00, irq_out}, 8'h01);
        if (irq_out !== 1'b1) test_done();
    endtask : wait_irq
    task automatic note(input string s);
        $display("test %s done, mismatches %0d", s, err_count);
    endtask : note
    task automatic reset_dut();
        rst_b_in <= 1'b0;
        repeat (20) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
    endtask : reset_dut

    initial begin
        int d;
        int e;
        req = '0;
        rst_b_in = 1'b0;
        osc_stopped = 1'b0;
        serial_mode = 2'h0;
        reset_dut();
        foreach (row_a[i]) rchk(row_a[i], 8'h00);
        foreach (row_a[i]) begin
            wr(row_a[i], row_d[i]);
            rchk(row_a[i], row_e[i]);
        end
        note("registers");
        // Carry in reload mode
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CNT_LO, 8'hff);
        wr(ADDR_CNT_HI, 8'hff);
        wr(ADDR_CTRL, 8'h04);
        wait_irq();
        rchk(ADDR_CNT_HI, 8'h34);
        rchk(ADDR_CTRL, 8'h84);
        wr(ADDR_CTRL, 8'h04);
        repeat (3) @(posedge sys_clk_in);
        chk({7'h00, irq_out}, 8'h00);
        note("reload carry");
        // Pin edge reload, then edge disabled
        wr(ADDR_CTRL, 8'h0c);
        wr(ADDR_CNT_HI, 8'hab);
        far_u.pulse(1'b1);
        rchk(ADDR_CNT_HI, 8'h34);
        rchk(ADDR_CTRL, 8'h4c);
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_CNT_HI, 8'hab);
        far_u.pulse(1'b1);
        rchk(ADDR_CNT_HI, 8'hab);
        rchk(ADDR_CTRL, 8'h04);
        note("edge reload");
        // Halted: flag still set, counter frozen
        wr(ADDR_CTRL, 8'h08);
        wr(ADDR_CNT_LO, 8'h00);
        far_u.pulse(1'b1);
        rchk(ADDR_CNT_LO, 8'h00);
        rchk(ADDR_CNT_HI, 8'hab);
        rchk(ADDR_CTRL, 8'h48);
        // Counter far from overflow, pins idle
        osc_stopped <= 1'b1;
        wr(ADDR_CTRL, 8'h04);
        repeat (50) @(posedge sys_clk_in);
        rchk(ADDR_CNT_LO, 8'h00);
        osc_stopped <= 1'b0;
        note("halt");
        // Capture keeps counting
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_CNT_HI, 8'h00);
        wr(ADDR_CTRL, 8'h0d);
        far_u.pulse(1'b1);
        rchk(ADDR_RLD_HI, 8'h00);
        rchk(ADDR_CTRL, 8'h4d);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CNT_LO, 8'h00);
        wr(ADDR_CTRL, 8'h06);
        repeat (3) far_u.pulse(1'b0);
        rchk(ADDR_CNT_LO, 8'h03);
        note("capture and pin count");
        // Baud: 16 counts at half rate give a carry every 32 clocks
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_RLD_LO, 8'hf0);
        wr(ADDR_RLD_HI, 8'hff);
        wr(ADDR_CNT_LO, 8'hf0);
        wr(ADDR_CNT_HI, 8'hff);
        wr(ADDR_CTRL, 8'h3d);
        for (int m = 0; m < 4; m++) begin
            serial_mode <= 2'(m);
            repeat (4) @(posedge sys_clk_in);
            d = rx_n;
            e = tx_n;
            repeat (200) @(posedge sys_clk_in);
            d = rx_n - d;
            e = tx_n - e;
            chk({7'h00, (m % 2 == 1) ? (d >= 5 && d <= 7) : (d == 0)}, 8'h01);
            chk({7'h00, (m % 2 == 1) ? (e >= 5 && e <= 7) : (e == 0)}, 8'h01);
        end
        wr(ADDR_CTRL, 8'h2d);
        // A tick launched at the write edge may still be in flight
        repeat (2) @(posedge sys_clk_in);
        d = tx_n;
        repeat (100) @(posedge sys_clk_in);
        chk(8'(tx_n - d), 8'h00);
        rchk(ADDR_CTRL, 8'h2d);
        rchk(ADDR_RLD_LO, 8'hf0);
        wr(ADDR_CTRL, 8'h3d);
        far_u.pulse(1'b1);
        rchk(ADDR_CTRL, 8'h7d);
        note("baud");
        reset_dut();
        @(posedge sys_clk_in);
        chk({7'h00, irq_out}, 8'h00);
        rchk(ADDR_CTRL, CTRL_RESET);
        note("mid reset");
        test_done();
    end
endmodule : timer2_reload_capture_baud_bench
